// [rtl/tvf_fetch.sv]
// Vector lookup, descriptor fetch, normal-mode counting and interrupts
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "tvf_params.svh"
module tvf_fetch
  import tvf_pkg::*;
#(
  parameter int NSRC = `TVF_NUM_SRC
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic [11:0]     paddr,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [NSRC-1:0] src_event,
  input  wire logic            nmi_event,
  input  wire logic            addr_fault_event,
  output tvf_rd_req_t          mem_rd,
  input  wire logic            mem_ack,
  input  wire logic [31:0]     mem_rdata,
  output tvf_desc_t            desc,
  output logic                 desc_valid,
  input  wire logic            xfer_done,
  output logic [NSRC-1:0]      cpu_src_irq,
  output logic                 cpu_soft_irq,
  output logic                 irq
);
  logic [NSRC-1:0]   activation_enable_bits;
  logic              nonmaskable_event_flag;
  logic              address_fault_flag;
  logic              soft_activation_enable;
  logic [7:0]        soft_vector_select;
  logic [15:0]       info_base_upper;
  logic [2:0]        status;
  logic [2:0]        mask;
  logic [15:0]       xfer_cnt;
  tvf_state_t        state;
  logic [5:0]        cur_src;
  logic              cur_soft;
  logic [31:0]       desc_base;
  logic [15:0]       vec_addr;
  logic [NSRC-1:0]   pend;
  logic              pick_hw;
  logic [5:0]        pick;
  logic              wr_en;
  logic              rd_en;
  logic              last_xfer;
  logic              irq_now;
  logic [1:0]        mode_sel;

  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // Lowest index wins, which is the lowest vector address
  always_comb begin
    pend    = src_event & activation_enable_bits;
    pick_hw = 1'b0;
    pick    = 6'h00;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        pick_hw = 1'b1;
        pick    = 6'(i);
      end
    end
  end

  // Fixed slot per source; software slot from the select field
  function automatic logic [15:0] slot_addr(input logic [5:0] idx);
    slot_addr = 16'(`TVF_VEC_BASE + {9'h000, idx, 1'b0});
  endfunction

  assign mode_sel  = desc.mode[`TVF_MODE_LSB +: 2];
  assign last_xfer = (desc.count == 16'h0001);
  assign irq_now   = xfer_done && (last_xfer || desc.mode[`TVF_PER_TRANSFER_IRQ_SELECT_BIT]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= TVF_IDLE;
      cur_src   <= 6'h00;
      cur_soft  <= 1'b0;
      vec_addr  <= 16'h0000;
      desc_base <= 32'h0000_0000;
      desc      <= '0;
    end else begin
      unique case (state)
        TVF_IDLE: begin
          // Faults hold off new activations
          if (!nonmaskable_event_flag && !address_fault_flag) begin
            if (pick_hw) begin
              cur_src  <= pick;
              cur_soft <= 1'b0;
              vec_addr <= slot_addr(pick);
              state    <= TVF_VEC;
            end else if (soft_activation_enable) begin
              cur_soft <= 1'b1;
              vec_addr <= 16'(`TVF_VEC_BASE + {8'h00, soft_vector_select});
              state    <= TVF_VEC;
            end
          end
        end
        TVF_VEC: if (mem_ack) begin
          // Big-endian halfword in the low 16 bits of the answer
          desc_base <= {info_base_upper, mem_rdata[15:0]};
          state     <= TVF_MODE;
        end
        TVF_MODE: if (mem_ack) begin
          desc.mode  <= mem_rdata[31:16];
          desc.count <= mem_rdata[15:0];
          state      <= (mem_rdata[16 +: 2] == `TVF_MODE_REPEAT) ? TVF_IADR : TVF_SKIP;
        end
        TVF_SKIP: if (mem_ack) begin
          desc.blen <= mem_rdata[15:0];
          state     <= TVF_SRC;
        end
        TVF_IADR: if (mem_ack) begin
          desc.iaddr <= mem_rdata;
          state      <= TVF_SRC;
        end
        TVF_SRC: if (mem_ack) begin
          desc.src <= mem_rdata;
          state    <= TVF_DST;
        end
        TVF_DST: if (mem_ack) begin
          desc.dst <= mem_rdata;
          state    <= TVF_DONE;
        end
        TVF_DONE: if (xfer_done) begin
          desc.count <= 16'(desc.count - 16'h0001);
          state      <= TVF_IDLE;
        end
        default: state <= TVF_IDLE;
      endcase
    end
  end

  // Read request per fetch step
  always_comb begin
    mem_rd.req  = 1'b0;
    mem_rd.wide = 1'b1;
    mem_rd.addr = desc_base;
    unique case (state)
      TVF_VEC: begin
        mem_rd.req  = 1'b1;
        mem_rd.wide = 1'b0;
        mem_rd.addr = {16'h0000, vec_addr};
      end
      TVF_MODE: mem_rd.req = 1'b1;
      TVF_SKIP, TVF_IADR: begin
        mem_rd.req  = 1'b1;
        mem_rd.addr = 32'(desc_base + 32'h4);
      end
      TVF_SRC: begin
        mem_rd.req  = 1'b1;
        mem_rd.addr = 32'(desc_base + 32'h8);
      end
      TVF_DST: begin
        mem_rd.req  = 1'b1;
        mem_rd.addr = 32'(desc_base + 32'hC);
      end
      default: mem_rd.req = 1'b0;
    endcase
  end
  assign desc_valid = (state == TVF_DONE);

  // Processor interrupt pulses per source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_src_irq  <= '0;
      cpu_soft_irq <= 1'b0;
    end else begin
      cpu_src_irq  <= '0;
      cpu_soft_irq <= 1'b0;
      if (state == TVF_DONE && irq_now) begin
        if (cur_soft) cpu_soft_irq <= 1'b1;
        else cpu_src_irq[cur_src] <= 1'b1;
      end
    end
  end

  // Enables, soft control and base register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      activation_enable_bits <= '0;
      soft_activation_enable <= 1'b0;
      soft_vector_select     <= 8'h00;
      info_base_upper        <= 16'h0000;
    end else begin
      if (wr_en && paddr == `TVF_OFF_ENABLE_LO)
        activation_enable_bits[31:0] <= pwdata;
      if (wr_en && paddr == `TVF_OFF_ENABLE_HI)
        activation_enable_bits[NSRC-1:32] <= pwdata[NSRC-33:0];
      if (wr_en && paddr == `TVF_OFF_BASE)
        info_base_upper <= pwdata[15:0];
      if (wr_en && paddr == `TVF_OFF_SOFT_CTL) begin
        soft_activation_enable <= pwdata[`TVF_BIT_SOFT_ACTIVATION_ENABLE];
        if (!soft_activation_enable)
          soft_vector_select <= {pwdata[7:1], 1'b0};
      end
      // Hardware clear after the transfer wins over a same-cycle write
      if (state == TVF_DONE && xfer_done) begin
        if (!cur_soft && irq_now)
          activation_enable_bits[cur_src] <= 1'b0;
        if (cur_soft && !irq_now)
          soft_activation_enable <= 1'b0;
      end
    end
  end

  // Fault flags: set wins over a zero write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nonmaskable_event_flag <= 1'b0;
      address_fault_flag     <= 1'b0;
    end else begin
      if (wr_en && paddr == `TVF_OFF_SOFT_CTL) begin
        if (!pwdata[`TVF_BIT_NONMASKABLE_EVENT_FLAG]) nonmaskable_event_flag <= 1'b0;
        if (!pwdata[`TVF_BIT_AE])   address_fault_flag     <= 1'b0;
      end
      if (nmi_event)        nonmaskable_event_flag <= 1'b1;
      if (addr_fault_event) address_fault_flag     <= 1'b1;
    end
  end

  // Sticky status, mask and completed-transfer count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status   <= 3'h0;
      mask     <= 3'h0;
      xfer_cnt <= 16'h0000;
    end else begin
      if (wr_en && paddr == `TVF_OFF_MASK) mask <= pwdata[2:0];
      if (wr_en && paddr == `TVF_OFF_STATUS) status <= status & ~pwdata[2:0];
      if (state == TVF_DONE && xfer_done) begin
        status[`TVF_ST_DONE] <= 1'b1;
        xfer_cnt             <= 16'(xfer_cnt + 16'h0001);
        if (irq_now) status[`TVF_ST_SRCIRQ] <= 1'b1;
      end
      if (nmi_event || addr_fault_event) status[`TVF_ST_FAULT] <= 1'b1;
    end
  end
  assign irq = |(status & mask);

  // Read mux
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `TVF_OFF_ENABLE_LO: prdata <= activation_enable_bits[31:0];
        `TVF_OFF_ENABLE_HI: prdata <= 32'(activation_enable_bits[NSRC-1:32]);
        `TVF_OFF_SOFT_CTL:  prdata <= {21'h000000, nonmaskable_event_flag,
                                       address_fault_flag, soft_activation_enable,
                                       soft_vector_select};
        `TVF_OFF_BASE:      prdata <= {16'h0000, info_base_upper};
        `TVF_OFF_STATUS:    prdata <= {29'h00000000, status};
        `TVF_OFF_MASK:      prdata <= {29'h00000000, mask};
        `TVF_OFF_XFER_CNT:  prdata <= {16'h0000, xfer_cnt};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Checks
  property p_fault_blocks;
    @(posedge pclk) disable iff (!presetn)
      (state == TVF_IDLE && (nonmaskable_event_flag || address_fault_flag))
        |=> state == TVF_IDLE;
  endproperty
  a_fault_blocks: assert property (p_fault_blocks) else $error("start under fault");

  property p_vec_addr;
    @(posedge pclk) disable iff (!presetn)
      (state == TVF_VEC && !cur_soft) |-> vec_addr == 16'(16'h0400 + {9'h0, cur_src, 1'b0});
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("bad vector slot");

  property p_soft_vec;
    @(posedge pclk) disable iff (!presetn)
      (state == TVF_VEC && cur_soft) |-> vec_addr == 16'(16'h0400 + soft_vector_select);
  endproperty
  a_soft_vec: assert property (p_soft_vec) else $error("bad soft vector");

  property p_base_join;
    @(posedge pclk) disable iff (!presetn)
      (state == TVF_VEC && mem_ack) |=>
        desc_base == {$past(info_base_upper), $past(mem_rdata[15:0])};
  endproperty
  a_base_join: assert property (p_base_join) else $error("bad descriptor base");

  property p_vec_first;
    @(posedge pclk) disable iff (!presetn)
      (state == TVF_IDLE && pick_hw && !nonmaskable_event_flag && !address_fault_flag)
        |=> state == TVF_VEC && !mem_rd.wide;
  endproperty
  a_vec_first: assert property (p_vec_first) else $error("vector not read first");

  property p_repeat_order;
    @(posedge pclk) disable iff (!presetn)
      (state == TVF_MODE && mem_ack && mem_rdata[17:16] == 2'h1) |=> state == TVF_IADR;
  endproperty
  a_repeat_order: assert property (p_repeat_order) else $error("repeat order");

  property p_last_irq;
    @(posedge pclk) disable iff (!presetn)
      (state == TVF_DONE && xfer_done && last_xfer && !cur_soft) |=> cpu_src_irq != '0;
  endproperty
  a_last_irq: assert property (p_last_irq) else $error("no end interrupt");

  property p_en_clear;
    @(posedge pclk) disable iff (!presetn)
      (state == TVF_DONE && xfer_done && irq_now && !cur_soft)
        |=> !activation_enable_bits[$past(cur_src)];
  endproperty
  a_en_clear: assert property (p_en_clear) else $error("enable not cleared");

  property p_per_transfer_irq_select;
    @(posedge pclk) disable iff (!presetn)
      (state == TVF_DONE && xfer_done && desc.mode[2] && cur_soft) |=> cpu_soft_irq;
  endproperty
  a_per_transfer_irq_select: assert property (p_per_transfer_irq_select) else $error("no per-transfer irq");

  c_hw_fetch: cover property (@(posedge pclk) state == TVF_VEC ##[1:20] state == TVF_DONE);
  c_soft:     cover property (@(posedge pclk) state == TVF_VEC && cur_soft);
  c_irq:      cover property (@(posedge pclk) irq);
  c_block:    cover property (@(posedge pclk) desc_valid && mode_sel == `TVF_MODE_BLOCK);
endmodule

// [rtl/tvf_params.svh]
// Constants for the transfer controller vector and descriptor fetch block
`ifndef TVF_PARAMS_SVH
`define TVF_PARAMS_SVH
`define TVF_VEC_BASE       16'h0400
`define TVF_NUM_SRC        33
`define TVF_OFF_ENABLE_LO  12'h000
`define TVF_OFF_ENABLE_HI  12'h004
`define TVF_OFF_SOFT_CTL   12'h008
`define TVF_OFF_BASE       12'h00C
`define TVF_OFF_STATUS     12'h010
`define TVF_OFF_MASK       12'h014
`define TVF_OFF_XFER_CNT   12'h018
`define TVF_BIT_NONMASKABLE_EVENT_FLAG       10
`define TVF_BIT_AE         9
`define TVF_BIT_SOFT_ACTIVATION_ENABLE      8
`define TVF_MODE_LSB       0
`define TVF_PER_TRANSFER_IRQ_SELECT_BIT      2
`define TVF_MODE_NORMAL    2'h0
`define TVF_MODE_REPEAT    2'h1
`define TVF_MODE_BLOCK     2'h2
`define TVF_ST_DONE        0
`define TVF_ST_SRCIRQ      1
`define TVF_ST_FAULT       2
`endif

// [rtl/tvf_pkg.sv]
// Types for the transfer controller vector and descriptor fetch block
package tvf_pkg;
  typedef struct packed {
    logic        req;
    logic        wide;
    logic [31:0] addr;
  } tvf_rd_req_t;
  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] iaddr;
    logic [15:0] mode;
    logic [15:0] count;
    logic [15:0] blen;
  } tvf_desc_t;
  typedef enum logic [8:0] {
    TVF_IDLE  = 9'h001,
    TVF_VEC   = 9'h002,
    TVF_MODE  = 9'h004,
    TVF_SKIP  = 9'h008,
    TVF_IADR  = 9'h010,
    TVF_BLEN  = 9'h020,
    TVF_SRC   = 9'h040,
    TVF_DST   = 9'h080,
    TVF_DONE  = 9'h100
  } tvf_state_t;
endpackage

// [verification/tvf_fetch_bench.sv]
// Self-checking bench for the vector and descriptor fetch block
`timescale 1ns/1ps
`include "tvf_params.svh"
module tvf_fetch_bench
  import tvf_pkg::*;
;
  localparam logic [15:0] BASE = 16'h2000;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [32:0] src_event = 33'h0;
  logic        nmi_event = 1'b0;
  logic        addr_fault_event = 1'b0;
  logic        xfer_done = 1'b0;
  logic        mem_ack;
  logic [31:0] mem_rdata;
  logic [3:0]  lag = 4'h0;
  logic [32:0] cpu_src_irq;
  logic        cpu_soft_irq;
  logic        irq;
  logic        desc_valid;
  tvf_rd_req_t mem_rd;
  tvf_desc_t   desc;
  int          fail_count = 0;
  int          n_checks = 0;
  always #20 pclk = ~pclk;
  tvf_fetch DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .src_event(src_event), .nmi_event(nmi_event),
    .addr_fault_event(addr_fault_event), .mem_rd(mem_rd), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .desc(desc), .desc_valid(desc_valid), .xfer_done(xfer_done),
    .cpu_src_irq(cpu_src_irq), .cpu_soft_irq(cpu_soft_irq), .irq(irq));
  tvf_mem_model mem (.pclk(pclk), .presetn(presetn), .mem_rd(mem_rd), .lag(lag),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fail_count++;
      results();
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk($sformatf("register %h", a), {1'b0, r}, {1'b0, e});
    chk("slave error", pslverr, 1'b0);
  endtask
  // Descriptors at multiples of four, plain memory as source and target
  task automatic prep(input logic [31:0] va, input logic [15:0] vec, input logic [31:0] w0);
    logic [31:0] b;
    b = {BASE, vec};
    mem.put16(va, vec);
    mem.put32(b, w0);
    mem.put32(b + 32'h4, {~vec, vec});
    mem.put32(b + 32'h8, {vec, 16'h1111});
    mem.put32(b + 32'hC, {vec, 16'h2222});
  endtask
  task automatic fetch(input logic [31:0] va, input logic [15:0] vec);
    logic [31:0] b;
    logic [31:0] w0;
    logic [31:0] w1;
    logic [32:0] e [5];
    int          n;
    b = {BASE, vec};
    w0 = mem.get32(b);
    w1 = mem.get32(b + 32'h4);
    e = '{{1'b0, va}, {1'b1, b}, {1'b1, b + 32'h4}, {1'b1, b + 32'h8}, {1'b1, b + 32'hC}};
    n = 0;
    while (desc_valid !== 1'b1 && n < 300) begin
      @(posedge pclk);
      #1;
      n++;
    end
    if (desc_valid !== 1'b1) begin
      fail_count++;
      results();
    end
    chk("read count", mem.log_q.size(), 5);
    foreach (e[i]) chk("read address", mem.log_q[i], e[i]);
    chk("mode word", desc.mode, w0[31:16]);
    chk("count word", desc.count, w0[15:0]);
    chk("source", desc.src, mem.get32(b + 32'h8));
    chk("destination", desc.dst, mem.get32(b + 32'hC));
    if (w0[17:16] == `TVF_MODE_REPEAT) chk("initial", desc.iaddr, w1);
    if (w0[17:16] == `TVF_MODE_BLOCK) chk("length", desc.blen, w1[15:0]);
    mem.log_q.delete();
  endtask
  task automatic done(input logic [32:0] s, input logic sw = 1'b0);
    @(posedge pclk);
    xfer_done <= 1'b1;
    src_event <= 33'h0;
    @(posedge pclk);
    xfer_done <= 1'b0;
    #1;
    chk("source irq", cpu_src_irq, s);
    chk("soft irq", cpu_soft_irq, sw);
  endtask
  task automatic t_regs();
    for (int a = 0; a < 32; a += 4) rd(a[11:0], 32'h0);
    wr(`TVF_OFF_BASE, {16'h0, BASE});
    rd(`TVF_OFF_BASE, {16'h0, BASE});
    wr(12'h01C, 32'hFFFFFFFF);
    rd(12'h01C, 32'h0);
    $display("test registers ended");
  endtask
  task automatic t_normal();
    lag <= 4'h2;
    wr(`TVF_OFF_MASK, 32'h7);
    wr(`TVF_OFF_ENABLE_LO, 32'h8);
    prep(32'h406, 16'h1000, 32'h00000002);
    @(posedge pclk);
    src_event[3] <= 1'b1;
    fetch(32'h406, 16'h1000);
    done(33'h0);
    rd(`TVF_OFF_ENABLE_LO, 32'h8);
    prep(32'h406, 16'h1100, 32'h00000001);
    @(posedge pclk);
    src_event[3] <= 1'b1;
    fetch(32'h406, 16'h1100);
    done(33'h8);
    rd(`TVF_OFF_ENABLE_LO, 32'h0);
    rd(`TVF_OFF_STATUS, 32'h3);
    chk("irq", irq, 1'b1);
    wr(`TVF_OFF_STATUS, 32'h3);
    #1;
    chk("irq", irq, 1'b0);
    rd(`TVF_OFF_XFER_CNT, 32'h2);
    $display("test normal ended");
  endtask
  task automatic t_prio();
    lag <= 4'h0;
    wr(`TVF_OFF_ENABLE_LO, 32'h1);
    wr(`TVF_OFF_ENABLE_HI, 32'h1);
    prep(32'h400, 16'h2000, 32'h00020003);
    @(posedge pclk);
    src_event <= {1'b1, 31'h0, 1'b1};
    fetch(32'h400, 16'h2000);
    done(33'h0);
    prep(32'h440, 16'h3000, 32'h00050007);
    @(posedge pclk);
    src_event[32] <= 1'b1;
    fetch(32'h440, 16'h3000);
    done({1'b1, 32'h0});
    rd(`TVF_OFF_ENABLE_HI, 32'h0);
    $display("test priority ended");
  endtask
  task automatic t_fault();
    logic bad;
    lag <= 4'h1;
    bad = 1'b0;
    prep(32'h40A, 16'h4000, 32'h00000002);
    prep(32'h442, 16'h5000, 32'h00000002);
    @(posedge pclk);
    nmi_event <= 1'b1;
    @(posedge pclk);
    nmi_event <= 1'b0;
    wr(`TVF_OFF_ENABLE_LO, 32'h21);
    wr(`TVF_OFF_SOFT_CTL, 32'h542);
    @(posedge pclk);
    src_event[5] <= 1'b1;
    addr_fault_event <= 1'b1;
    @(posedge pclk);
    addr_fault_event <= 1'b0;
    repeat (20) begin
      @(posedge pclk);
      if (mem_rd.req !== 1'b0) bad = 1'b1;
    end
    chk("start while flagged", bad, 1'b0);
    rd(`TVF_OFF_SOFT_CTL, 32'h742);
    rd(`TVF_OFF_STATUS, 32'h7);
    chk("irq", irq, 1'b1);
    wr(`TVF_OFF_MASK, 32'h0);
    #1;
    chk("irq masked", irq, 1'b0);
    wr(`TVF_OFF_MASK, 32'h7);
    wr(`TVF_OFF_STATUS, 32'h7);
    wr(`TVF_OFF_SOFT_CTL, 32'h100);
    fetch(32'h40A, 16'h4000);
    done(33'h0);
    fetch(32'h442, 16'h5000);
    done(33'h0);
    rd(`TVF_OFF_SOFT_CTL, 32'h042);
    // Per-transfer select keeps the soft enable, so a second run follows
    prep(32'h442, 16'h5000, 32'h00040002);
    wr(`TVF_OFF_SOFT_CTL, 32'h142);
    fetch(32'h442, 16'h5000);
    done(33'h0, 1'b1);
    rd(`TVF_OFF_SOFT_CTL, 32'h142);
    wr(`TVF_OFF_SOFT_CTL, 32'h000);
    fetch(32'h442, 16'h5000);
    done(33'h0, 1'b1);
    rd(`TVF_OFF_SOFT_CTL, 32'h042);
    $display("test fault and software ended");
  endtask
  // Reset in the middle of a fetch
  task automatic t_reset();
    wr(`TVF_OFF_ENABLE_LO, 32'h1);
    @(posedge pclk);
    src_event[0] <= 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b0;
    src_event <= 33'h0;
    repeat (2) @(posedge pclk);
    #1;
    chk("request in reset", mem_rd.req, 1'b0);
    chk("irq in reset", irq, 1'b0);
    chk("valid in reset", desc_valid, 1'b0);
    @(posedge pclk);
    presetn <= 1'b1;
    rd(`TVF_OFF_ENABLE_LO, 32'h0);
    rd(`TVF_OFF_BASE, 32'h0);
    rd(`TVF_OFF_STATUS, 32'h0);
    mem.log_q.delete();
    $display("test reset ended");
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_normal();
    t_prio();
    t_fault();
    t_reset();
    results();
  end
endmodule

// [verification/tvf_mem_model.sv]
// Memory side model answering vector and descriptor reads
`timescale 1ns/1ps
module tvf_mem_model
  import tvf_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  tvf_rd_req_t     mem_rd,
  input  wire logic [3:0] lag,
  output logic            mem_ack,
  output logic [31:0]     mem_rdata
);
  logic [7:0]  mem [bit [31:0]];
  logic [32:0] log_q [$];
  logic [3:0]  wait_n;
  function automatic logic [7:0] rd8(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : 8'hA5;
  endfunction
  function automatic logic [31:0] get32(input logic [31:0] a);
    return {rd8(a), rd8(a + 32'h1), rd8(a + 32'h2), rd8(a + 32'h3)};
  endfunction
  // Big-endian byte placement
  task automatic put16(input logic [31:0] a, input logic [15:0] v);
    mem[a] = v[15:8];
    mem[a + 32'h1] = v[7:0];
  endtask
  task automatic put32(input logic [31:0] a, input logic [31:0] v);
    put16(a, v[31:16]);
    put16(a + 32'h2, v[15:0]);
  endtask
  // Answers after lag cycles; data lines toggle outside the ack cycle
  // Plain always: the bench also empties the request log
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h5A5A5A5A;
      wait_n    <= 4'h0;
    end else if (mem_ack) begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (mem_rd.req && wait_n >= lag) begin
      mem_ack   <= 1'b1;
      wait_n    <= 4'h0;
      log_q.push_back({mem_rd.wide, mem_rd.addr});
      mem_rdata <= mem_rd.wide ? get32(mem_rd.addr)
                               : {16'hC3C3, rd8(mem_rd.addr), rd8(mem_rd.addr + 32'h1)};
    end else begin
      mem_rdata <= ~mem_rdata;
      wait_n    <= mem_rd.req ? wait_n + 4'h1 : 4'h0;
    end
  end
endmodule
